//--- hw/dans_regs.vh
// Constants for the damping filter and adaptive notch selection block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Function
// - Mode 0 keeps filters one and two active
// - Mode 1: contact A picks one/three or two/four
// - Mode 2: both contacts decode filters one to four
// - Mode 3: forward one/three, reverse two/four
// - Damping frequencies held in 0.1 Hz steps
// - Inactive filter's adjustment is ignored
// - Adaptive select: off, one, two, measure, clear
// - Select 4 disables notch three, four, result
// - Estimates written into notch three or four
// - Notch three/four saved every 30 minutes, restored
// - Adaptation suspended under torque control
// - Torque via control mode 5/6 keeps notches
// - Damping frequency 0 means filter unused
`ifndef DANS_REGS_VH
`define DANS_REGS_VH

`define DANS_ADDR_CTRL      6'h00
`define DANS_ADDR_DFREQ1    6'h04
`define DANS_ADDR_DADJ1     6'h08
`define DANS_ADDR_DFREQ2    6'h0c
`define DANS_ADDR_DFREQ3    6'h10
`define DANS_ADDR_DFREQ4    6'h14
`define DANS_ADDR_NOTCH3    6'h18
`define DANS_ADDR_NOTCH4    6'h1c
`define DANS_ADDR_STATUS    6'h20

`define DANS_CTRL_SWM_LSB   0
`define DANS_CTRL_ADS_LSB   4
`define DANS_CTRL_CMS_LSB   8
`define DANS_CTRL_RIG_LSB   12

`define DANS_SWM_FIXED      2'h0
`define DANS_SWM_ONE_IN     2'h1
`define DANS_SWM_TWO_IN     2'h2
`define DANS_SWM_DIR        2'h3

`define DANS_ADS_OFF        3'h0
`define DANS_ADS_ONE        3'h1
`define DANS_ADS_TWO        3'h2
`define DANS_ADS_MEASURE    3'h3
`define DANS_ADS_CLEAR      3'h4

`define DANS_CMS_KEEP_A     4'h5
`define DANS_CMS_KEEP_B     4'h6

`define DANS_NOTCH_OFF      16'h1388
`define DANS_CTRL_RST       32'h0000_0000
`define DANS_FREQ_RST       16'h0000

`define DANS_CLK_HZ         36'd25000000
`define DANS_SAVE_MINUTES   36'd30
`define DANS_SAVE_CYCLES    (`DANS_SAVE_MINUTES * 36'd60 * `DANS_CLK_HZ)
`define DANS_DEB_US         16'd1000
`define DANS_DEB_CYCLES     (`DANS_DEB_US * 16'd25)

`endif

//--- hw/dans_contact_filter.v
// Synchroniser and debouncer for one external select contact.
// Assumes the contact is asynchronous to clk_i; output is the stable level.
`include "dans_regs.vh"

module dans_contact_filter #(
	parameter [15:0] DEB_CYCLES = `DANS_DEB_CYCLES
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        pin_i,
	output reg         level_o
);
	reg        meta_ff;
	reg        s2_ff;
	reg        s3_ff;
	reg [15:0] cnt_ff;
	reg [15:0] nxt_cnt;

	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= 1'b0;
			s2_ff   <= 1'b0;
			s3_ff   <= 1'b0;
		end else begin
			meta_ff <= pin_i;
			s2_ff   <= meta_ff;
			s3_ff   <= s2_ff;
		end
	end

	// Level must hold DEB_CYCLES before it is accepted
	always @* begin
		nxt_cnt = 16'h0000;
		if (s2_ff == s3_ff && s3_ff != level_o)
			nxt_cnt = cnt_ff + 16'h0001;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff  <= 16'h0000;
			level_o <= 1'b0;
		end else if (nxt_cnt >= DEB_CYCLES) begin
			cnt_ff  <= 16'h0000;
			level_o <= s3_ff;
		end else begin
			cnt_ff  <= nxt_cnt;
		end
	end
endmodule

//--- hw/dans_top.v
// Damping filter selection and adaptive notch management, Wishbone slave.
// Assumes an estimator supplies resonance estimates and an NVM agent stores
// notch values; select contacts come straight from pins.
`include "dans_regs.vh"

module dans_top #(
	parameter [35:0] SAVE_CYCLES = `DANS_SAVE_CYCLES,
	parameter [15:0] DEB_CYCLES  = `DANS_DEB_CYCLES
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [5:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        filter_select_a_i,
	input  wire        filter_select_b_i,
	input  wire        cmd_reverse_i,
	input  wire        torque_active_i,
	input  wire        est_valid_i,
	input  wire        est_slot_i,
	input  wire [15:0] est_freq_i,
	input  wire        nvm_restore_i,
	input  wire [15:0] nvm_notch_three_i,
	input  wire [15:0] nvm_notch_four_i,
	output reg         nvm_save_o,
	output reg  [15:0] nvm_notch_three_o,
	output reg  [15:0] nvm_notch_four_o,
	output reg  [3:0]  damp_active_o,
	output reg  [15:0] damp_adjust_one_o,
	output reg  [1:0]  adapt_mode_o,
	output reg         adapt_run_o,
	output reg         notch_three_en_o,
	output reg         notch_four_en_o,
	output reg  [15:0] notch_three_freq_o,
	output reg  [15:0] notch_four_freq_o
);
	localparam [1:0] AM_OFF     = 2'h0;
	localparam [1:0] AM_ONE     = 2'h1;
	localparam [1:0] AM_TWO     = 2'h2;
	localparam [1:0] AM_MEASURE = 2'h3;

	// Byte-lane merge of a 32-bit register write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wr;
		input [3:0]  sel;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					merge[i*8 +: 8] = wr[i*8 +: 8];
		end
	endfunction

	// Byte-lane merge into a 16-bit register, upper lanes dropped
	function [15:0] merge_lo;
		input [15:0] old;
		input [31:0] wr;
		input [3:0]  sel;
		reg   [31:0] full;
		begin
			full     = merge({16'h0000, old}, wr, sel);
			merge_lo = full[15:0];
		end
	endfunction

	reg [31:0] ctrl_ff;
	reg [15:0] dfreq1_ff;
	reg [15:0] dadj1_ff;
	reg [15:0] dfreq2_ff;
	reg [15:0] dfreq3_ff;
	reg [15:0] dfreq4_ff;
	reg [15:0] notch3_ff;
	reg [15:0] notch4_ff;
	reg [35:0] save_cnt_ff;
	reg        torque_ff;
	reg [15:0] nxt_notch3;
	reg [15:0] nxt_notch4;
	reg [3:0]  nxt_active;
	reg [31:0] nxt_dat;
	reg [1:0]  nxt_mode;

	wire       sel_a;
	wire       sel_b;
	wire [1:0] swm   = ctrl_ff[`DANS_CTRL_SWM_LSB +: 2];
	wire [2:0] ads   = ctrl_ff[`DANS_CTRL_ADS_LSB +: 3];
	wire [3:0] cms   = ctrl_ff[`DANS_CTRL_CMS_LSB +: 4];
	wire       wb_go = cyc_i & stb_i & ~ack_o;
	wire       wb_wr = wb_go & we_i;
	wire       clear = (ads == `DANS_ADS_CLEAR);
	wire       keep  = (cms == `DANS_CMS_KEEP_A) || (cms == `DANS_CMS_KEEP_B);
	wire       tq_in = torque_active_i & ~torque_ff;
	wire       run   = (nxt_mode != AM_OFF) & ~torque_active_i;
	wire       take  = est_valid_i & run;
	wire       save  = (save_cnt_ff == SAVE_CYCLES - 36'd1);

	dans_contact_filter #(
		.DEB_CYCLES (DEB_CYCLES)
	) u_sel_a (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pin_i      (filter_select_a_i),
		.level_o    (sel_a)
	);

	dans_contact_filter #(
		.DEB_CYCLES (DEB_CYCLES)
	) u_sel_b (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pin_i      (filter_select_b_i),
		.level_o    (sel_b)
	);

	// Adaptive mode decode
	always @* begin
		case (ads)
			`DANS_ADS_ONE:     nxt_mode = AM_ONE;
			`DANS_ADS_TWO:     nxt_mode = AM_TWO;
			`DANS_ADS_MEASURE: nxt_mode = AM_MEASURE;
			default:           nxt_mode = AM_OFF;
		endcase
	end

	// Damping filter selection; closed contact reads as 1
	always @* begin
		case (swm)
			`DANS_SWM_FIXED:  nxt_active = 4'b0011;
			`DANS_SWM_ONE_IN: nxt_active = sel_a ? 4'b1010 : 4'b0101;
			`DANS_SWM_TWO_IN: begin
				case ({sel_b, sel_a})
					2'b00:   nxt_active = 4'b0001;
					2'b01:   nxt_active = 4'b0010;
					2'b10:   nxt_active = 4'b0100;
					default: nxt_active = 4'b1000;
				endcase
			end
			default:          nxt_active = cmd_reverse_i ? 4'b1010 : 4'b0101;
		endcase
		// Zero frequency leaves a filter unused
		if (dfreq1_ff == `DANS_FREQ_RST)
			nxt_active[0] = 1'b0;
		if (dfreq2_ff == `DANS_FREQ_RST)
			nxt_active[1] = 1'b0;
		if (dfreq3_ff == `DANS_FREQ_RST)
			nxt_active[2] = 1'b0;
		if (dfreq4_ff == `DANS_FREQ_RST)
			nxt_active[3] = 1'b0;
	end

	// Notch slot three and four update, priority low to high
	always @* begin
		nxt_notch3 = notch3_ff;
		nxt_notch4 = notch4_ff;
		if (wb_wr && adr_i == `DANS_ADDR_NOTCH3)
			nxt_notch3 = merge_lo(notch3_ff, dat_i, sel_i);
		if (wb_wr && adr_i == `DANS_ADDR_NOTCH4)
			nxt_notch4 = merge_lo(notch4_ff, dat_i, sel_i);
		if (take && !est_slot_i)
			nxt_notch3 = est_freq_i;
		if (take && est_slot_i && nxt_mode != AM_ONE)
			nxt_notch4 = est_freq_i;
		// Entering torque control drops the result unless mode 5 or 6
		if (tq_in && !keep) begin
			nxt_notch3 = `DANS_NOTCH_OFF;
			nxt_notch4 = `DANS_NOTCH_OFF;
		end
		if (clear) begin
			nxt_notch3 = `DANS_NOTCH_OFF;
			nxt_notch4 = `DANS_NOTCH_OFF;
		end
		if (nvm_restore_i) begin
			nxt_notch3 = nvm_notch_three_i;
			nxt_notch4 = nvm_notch_four_i;
		end
	end

	// Read data mux
	always @* begin
		case (adr_i)
			`DANS_ADDR_CTRL:   nxt_dat = ctrl_ff;
			`DANS_ADDR_DFREQ1: nxt_dat = {16'h0000, dfreq1_ff};
			`DANS_ADDR_DADJ1:  nxt_dat = {16'h0000, dadj1_ff};
			`DANS_ADDR_DFREQ2: nxt_dat = {16'h0000, dfreq2_ff};
			`DANS_ADDR_DFREQ3: nxt_dat = {16'h0000, dfreq3_ff};
			`DANS_ADDR_DFREQ4: nxt_dat = {16'h0000, dfreq4_ff};
			`DANS_ADDR_NOTCH3: nxt_dat = {16'h0000, notch3_ff};
			`DANS_ADDR_NOTCH4: nxt_dat = {16'h0000, notch4_ff};
			`DANS_ADDR_STATUS: nxt_dat = {22'h000000, torque_ff, sel_b, sel_a, notch_four_en_o,
			                              notch_three_en_o, adapt_run_o, damp_active_o};
			default:           nxt_dat = 32'h0000_0000;
		endcase
	end

	// Bus slave and configuration registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o     <= 1'b0;
			dat_o     <= 32'h0000_0000;
			ctrl_ff   <= `DANS_CTRL_RST;
			dfreq1_ff <= `DANS_FREQ_RST;
			dadj1_ff  <= `DANS_FREQ_RST;
			dfreq2_ff <= `DANS_FREQ_RST;
			dfreq3_ff <= `DANS_FREQ_RST;
			dfreq4_ff <= `DANS_FREQ_RST;
		end else begin
			ack_o <= wb_go;
			dat_o <= wb_go ? nxt_dat : 32'h0000_0000;
			if (wb_wr) begin
				// Frequencies stored as raw 0.1 Hz counts
				case (adr_i)
					`DANS_ADDR_CTRL:   ctrl_ff   <= merge(ctrl_ff, dat_i, sel_i) & 32'h0000_ff73;
					`DANS_ADDR_DFREQ1: dfreq1_ff <= merge_lo(dfreq1_ff, dat_i, sel_i);
					`DANS_ADDR_DADJ1:  dadj1_ff  <= merge_lo(dadj1_ff, dat_i, sel_i);
					`DANS_ADDR_DFREQ2: dfreq2_ff <= merge_lo(dfreq2_ff, dat_i, sel_i);
					`DANS_ADDR_DFREQ3: dfreq3_ff <= merge_lo(dfreq3_ff, dat_i, sel_i);
					`DANS_ADDR_DFREQ4: dfreq4_ff <= merge_lo(dfreq4_ff, dat_i, sel_i);
					default:           ;
				endcase
			end
		end
	end

	// Filter outputs, notch slots and periodic save
	always @(posedge clk_i) begin
		if (rst_i) begin
			damp_active_o      <= 4'h0;
			damp_adjust_one_o  <= 16'h0000;
			adapt_mode_o       <= AM_OFF;
			adapt_run_o        <= 1'b0;
			notch3_ff          <= `DANS_NOTCH_OFF;
			notch4_ff          <= `DANS_NOTCH_OFF;
			notch_three_en_o   <= 1'b0;
			notch_four_en_o    <= 1'b0;
			notch_three_freq_o <= `DANS_NOTCH_OFF;
			notch_four_freq_o  <= `DANS_NOTCH_OFF;
			torque_ff          <= 1'b0;
			save_cnt_ff        <= 36'd0;
			nvm_save_o         <= 1'b0;
			nvm_notch_three_o  <= `DANS_NOTCH_OFF;
			nvm_notch_four_o   <= `DANS_NOTCH_OFF;
		end else begin
			damp_active_o     <= nxt_active;
			damp_adjust_one_o <= nxt_active[0] ? dadj1_ff : 16'h0000;
			adapt_mode_o      <= nxt_mode;
			adapt_run_o       <= run;
			torque_ff         <= torque_active_i;
			notch3_ff         <= nxt_notch3;
			notch4_ff         <= nxt_notch4;
			notch_three_freq_o <= nxt_notch3;
			notch_four_freq_o  <= nxt_notch4;
			notch_three_en_o  <= (nxt_notch3 != `DANS_NOTCH_OFF) & ~clear;
			notch_four_en_o   <= (nxt_notch4 != `DANS_NOTCH_OFF) & ~clear;
			save_cnt_ff       <= save ? 36'd0 : save_cnt_ff + 36'd1;
			nvm_save_o        <= save;
			if (save) begin
				nvm_notch_three_o <= notch3_ff;
				nvm_notch_four_o  <= notch4_ff;
			end
		end
	end
endmodule

//--- verification/dans_top_monitor.sv
// Checker for dans_top, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
module dans_top_monitor (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        ack_o,
	input wire        torque_active_i,
	input wire        est_valid_i,
	input wire        est_slot_i,
	input wire [15:0] est_freq_i,
	input wire        nvm_restore_i,
	input wire [15:0] nvm_notch_three_i,
	input wire        nvm_save_o,
	input wire [15:0] nvm_notch_three_o,
	input wire [3:0]  damp_active_o,
	input wire [15:0] damp_adjust_one_o,
	input wire [1:0]  adapt_mode_o,
	input wire        adapt_run_o,
	input wire        notch_three_en_o,
	input wire [15:0] notch_three_freq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not a single pulse");
	run_torque_a: assert property (torque_active_i |=> !adapt_run_o)
		else $error("adaptation runs under torque control");
	run_mode_a: assert property (adapt_run_o |-> adapt_mode_o != 2'h0)
		else $error("adaptation runs while off");
	adj_idle_a: assert property (!damp_active_o[0] |-> damp_adjust_one_o == 16'h0)
		else $error("filter one adjustment used while inactive");
	notch_off_a: assert property (notch_three_en_o |-> notch_three_freq_o != 16'h1388)
		else $error("notch three enabled at off frequency");
	est_write_a: assert property (est_valid_i && !est_slot_i && adapt_run_o && !torque_active_i
		&& !nvm_restore_i && !cyc_i && !$past(cyc_i) |=> notch_three_freq_o == $past(est_freq_i))
		else $error("estimate not written to notch three");
	restore_load_a: assert property (nvm_restore_i |=> notch_three_freq_o == $past(nvm_notch_three_i))
		else $error("restored value not loaded");
	save_data_a: assert property (nvm_save_o |-> nvm_notch_three_o == $past(notch_three_freq_o))
		else $error("saved value differs from notch three");
endmodule

bind dans_top dans_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .torque_active_i(torque_active_i), .est_valid_i(est_valid_i), .est_slot_i(est_slot_i),
	.est_freq_i(est_freq_i), .nvm_restore_i(nvm_restore_i), .nvm_notch_three_i(nvm_notch_three_i),
	.nvm_save_o(nvm_save_o), .nvm_notch_three_o(nvm_notch_three_o), .damp_active_o(damp_active_o),
	.damp_adjust_one_o(damp_adjust_one_o), .adapt_mode_o(adapt_mode_o), .adapt_run_o(adapt_run_o),
	.notch_three_en_o(notch_three_en_o), .notch_three_freq_o(notch_three_freq_o));

//--- verification/dans_far_model.sv
// Far-side model: resonance estimator and nonvolatile notch store.
// Assumes its tasks are entered right after a rising edge.
module dans_far_model (
	input  wire         clk_i,
	output logic        est_valid_o,
	output logic        est_slot_o,
	output logic [15:0] est_freq_o,
	output logic        restore_o,
	output logic [15:0] nvm_three_o,
	output logic [15:0] nvm_four_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{est_valid_o, est_slot_o, restore_o, est_freq_o, nvm_three_o, nvm_four_o} = {3'h0, 48'h5a5a_a5a5_5a5a};
	end
	task automatic est(input logic s, input logic [15:0] f);
		est_valid_o <= 1'h1;
		est_slot_o <= s;
		est_freq_o <= f;
		@(posedge clk_i);
		est_valid_o <= 1'h0;
		est_freq_o <= ~f;
		@(posedge clk_i);
	endtask
	task automatic restore(input logic [15:0] a, input logic [15:0] b);
		restore_o <= 1'h1;
		nvm_three_o <= a;
		nvm_four_o <= b;
		@(posedge clk_i);
		restore_o <= 1'h0;
		nvm_three_o <= ~a;
		nvm_four_o <= ~b;
		@(posedge clk_i);
	endtask
endmodule

//--- verification/damping_and_adaptive_notch_select_tb.sv
// Self-checking bench for dans_top: bus, damping select, notch slots.
// Assumes dans_far_model plays estimator and nonvolatile store.
module damping_and_adaptive_notch_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_i, cyc, we, ack, fa, fb, rev, torq, ev, es, nr, sv, run, e3, e4;
	logic [5:0]  adr;
	logic [31:0] wd, rd, q;
	logic [15:0] ef, ni3, ni4, sv3, sv4, adj, f3, f4;
	logic [3:0]  act;
	logic [1:0]  am;
	int          miscompares = 0;
	int          n_compared = 0;
	int          ticks = 0;
	dans_top #(.SAVE_CYCLES(36'hc8), .DEB_CYCLES(16'h4)) u_dans_top (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hf),
		.dat_i(wd), .dat_o(rd), .ack_o(ack), .filter_select_a_i(fa), .filter_select_b_i(fb),
		.cmd_reverse_i(rev), .torque_active_i(torq), .est_valid_i(ev), .est_slot_i(es), .est_freq_i(ef),
		.nvm_restore_i(nr), .nvm_notch_three_i(ni3), .nvm_notch_four_i(ni4), .nvm_save_o(sv),
		.nvm_notch_three_o(sv3), .nvm_notch_four_o(sv4), .damp_active_o(act), .damp_adjust_one_o(adj),
		.adapt_mode_o(am), .adapt_run_o(run), .notch_three_en_o(e3), .notch_four_en_o(e4),
		.notch_three_freq_o(f3), .notch_four_freq_o(f4));
	dans_far_model u_dans_far_model (.clk_i(clk_i), .est_valid_o(ev), .est_slot_o(es), .est_freq_o(ef),
		.restore_o(nr), .nvm_three_o(ni3), .nvm_four_o(ni4));
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 4000) begin
			miscompares++;
			end_sim;
		end
	end
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic wr, input logic [5:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		we <= wr;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'h1);
		q = rd;
		chk("ack", 32'h1, ack);
		cyc <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic t_reset;
		chk("notch3_freq", 32'h1388, f3);
		chk("notch3_en", 32'h0, e3);
		wb(1'h0, 6'h3c, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
	endtask
	task automatic t_switch;
		logic [8:0] row [10] = '{9'h003, 9'h073, 9'h085, 9'h0ca, 9'h101, 9'h142, 9'h124, 9'h168, 9'h185, 9'h19a};
		wb(1'h1, 6'h04, 32'h64);
		wb(1'h1, 6'h08, 32'h32);
		wb(1'h1, 6'h0c, 32'hc8);
		wb(1'h1, 6'h10, 32'h12c);
		wb(1'h1, 6'h14, 32'h1f4);
		wb(1'h0, 6'h04, 32'h0);
		chk("freq_one", 32'h64, q);
		foreach (row[i]) begin
			{fa, fb, rev} <= row[i][6:4];
			wb(1'h1, 6'h00, {30'h0, row[i][8:7]});
			w(14);
			chk("damp_active", row[i][3:0], act);
			chk("adjust_one", row[i][0] ? 32'h32 : 32'h0, adj);
		end
		wb(1'h1, 6'h04, 32'h0);
		wb(1'h1, 6'h00, 32'h0);
		w(2);
		chk("damp_active", 32'h2, act);
		$display("test switch done");
	endtask
	task automatic t_adapt;
		for (int s = 0; s < 4; s++) begin
			wb(1'h1, 6'h00, s << 4);
			w(2);
			chk("adapt_mode", s, am);
			chk("adapt_run", s != 0, run);
		end
		torq <= 1'h1;
		w(2);
		chk("adapt_run", 32'h0, run);
		torq <= 1'h0;
		$display("test adapt done");
	endtask
	task automatic t_notch;
		wb(1'h1, 6'h00, 32'h20);
		u_dans_far_model.est(1'h0, 16'h0bb8);
		u_dans_far_model.est(1'h1, 16'h0fa0);
		w(2);
		chk("notch3_freq", 32'hbb8, f3);
		chk("notch4_freq", 32'hfa0, f4);
		wb(1'h1, 6'h18, 32'h1388);
		w(2);
		chk("notch3_en", 32'h0, e3);
		chk("notch4_en", 32'h1, e4);
		wb(1'h1, 6'h00, 32'h40);
		w(2);
		chk("notch4_freq", 32'h1388, f4);
		chk("notch4_en", 32'h0, e4);
		$display("test notch done");
	endtask
	task automatic t_torque;
		wb(1'h1, 6'h00, 32'h520);
		u_dans_far_model.est(1'h0, 16'h0c00);
		torq <= 1'h1;
		w(3);
		chk("notch3_freq", 32'hc00, f3);
		torq <= 1'h0;
		wb(1'h1, 6'h00, 32'h20);
		torq <= 1'h1;
		w(3);
		chk("notch3_freq", 32'h1388, f3);
		torq <= 1'h0;
		$display("test torque done");
	endtask
	task automatic t_nvm;
		int n;
		w(2);
		u_dans_far_model.est(1'h0, 16'h0d00);
		n = 0;
		while (sv !== 1'h1 && n < 250) begin
			@(posedge clk_i);
			n++;
		end
		chk("save", 32'h1, sv);
		chk("saved3", 32'hd00, sv3);
		chk("saved4", 32'h1388, sv4);
		u_dans_far_model.restore(16'h0a00, 16'h0b00);
		w(2);
		chk("notch3_freq", 32'ha00, f3);
		chk("notch4_freq", 32'hb00, f4);
		$display("test nvm done");
	endtask
	initial begin
		{rst_i, cyc, we, fa, fb, rev, torq} = 7'h40;
		adr = 6'h0;
		wd = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset;
		t_switch;
		t_adapt;
		t_notch;
		t_torque;
		t_nvm;
		end_sim;
	end
endmodule
